// ==== include/sdl_pkg.sv ====
// shared types and constants of the single-pin debug link
// assumes a 10 MHz system clock on ref_clk and an external pull-up on the debug line
package sdl_pkg;

  localparam int          CLK_HZ        = 10_000_000;
  // slowest bit rate is clock / 512; an autobaud count never exceeds 8 * 512
  localparam int          MAX_BIT_DIV   = 512;
  localparam int          MIN_BIT_DIV   = 4;
  localparam logic [15:0] BAUD_CNT_MAX  = 16'h1000;
  localparam logic [7:0]  SYNC_CHAR     = 8'h80;
  localparam logic [7:0]  BRK_OPCODE    = 8'h00;
  localparam logic [15:0] RUN_CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] RUN_CNT_RST   = 16'h0000;
  localparam int          DBG_MODE_BIT  = 7;
  localparam int          BRK_EN_BIT    = 5;
  localparam logic [7:0]  CTL_RST       = 8'h00;
  localparam int          BREAK_BITS    = 9;
  localparam int          REPLY_CHARS   = 4;
  localparam int          CHAR_BITS     = 10;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          FIFO_WIDTH    = 8;

  // one received or transmitted character with its framing result
  typedef struct packed {
    logic [7:0] data;
    logic       frameErr;
  } sdl_char_t;

  // pin of an open-drain line: sampled level, pull-low request
  typedef struct packed {
    logic lineIn;
    logic pullLow;
  } sdl_pin_t;

endpackage

// ==== logic/sdl_fifo.sv ====
// synchronous valid/ready fifo with parameterised width and depth
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
module sdl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady,
  input  wire logic             flush
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // honest full and empty from the fill count
  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // pointers and fill count
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else if (flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// ==== logic/sdl_link.sv ====
// single-pin open-drain debug link: autobaud, serial framing, errors, debug mode, runtime counter
// assumes an external pull-up on the debug line and a 10 MHz ref_clk
// What this block does, and what it expects of the host
// (RULE1) one open-drain line, half duplex: never transmit and receive together
// (RULE2) characters are start low, eight data bits lsb first, stop high
// (RULE3) idle after reset until 80H arrives; its low period sets the bit rate
// (RULE4) autobaud runs on the system clock, down to clock divided by 512
// (RULE5) host keeps bit rate at or below clock/8, never faster than clock/4
// (RULE6) nine or more low bit times is a break; it resets autobaud
// (RULE7) a low sampled stop bit is a framing error
// (RULE8) line low while sending a high bit is a collision error
// (RULE9) on any serial error abort, reply four-character break, reset autobaud; the code sends no reply break when a host break is the error
// (RULE10) host break resets autobaud only; control register and debug mode stay
// (RULE11) debugger held in reset while host break lasts, released when line high
// (RULE12) host sends a break at connect and on error recovery
// (RULE13) debug mode halts fetch except directed instructions; clock keeps running
// (RULE14) entering debug mode leaves halt; watchdog refreshed continuously in debug
// (RULE15) break opcode enters debug mode when breakpoints enabled, else no-operation
// (RULE16) line low in last reset cycle enters debug mode on leaving reset
// (RULE17) leave debug mode on flag written 0 or any system reset
// (RULE18) line driven low in stop mode starts a system reset
// (RULE19) 16-bit runtime counter counts outside debug mode, stops at FFFFH
// (RULE20) debug flag is control bit 7; read protection forbids clearing it
// (RULE21) each party only pulls low or releases; pull-up makes high
`timescale 1ns/1ps
module sdl_link (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        debug_line_pin_i,
  output logic             debug_line_pin_o,
  output logic             debug_line_pin_oe_n,
  output logic [7:0]       rxData,
  output logic             rxValid,
  input  wire logic        rxReady,
  input  wire logic [7:0]  txData,
  input  wire logic        txValid,
  output logic             txReady,
  input  wire logic        ctlWrite,
  input  wire logic [7:0]  ctlWrData,
  output logic [7:0]       debugger_control_register,
  input  wire logic        readProtect,
  input  wire logic        breakInstrDecoded,
  input  wire logic [7:0]  decodedOpcode,
  input  wire logic        stopMode,
  input  wire logic        sysResetLast,
  output logic             debug_mode_flag,
  output logic             fetchHalt,
  output logic             haltExit,
  output logic             watchdogRefresh,
  input  wire logic        watchdogEnabled,
  output logic             stopWakeReset,
  output logic [15:0]      runtimeCount,
  output logic             baudLocked,
  output logic             serialError
);
  typedef enum logic [4:0] {
    SDL_IDLE  = 5'b00001,
    SDL_SYNC  = 5'b00010,
    SDL_READY = 5'b00100,
    SDL_RX    = 5'b01000,
    SDL_TX    = 5'b10000
  } sdl_state_t;

  sdl_state_t  state_q;
  logic [2:0]  sync_q;
  logic        lineLvl_q;
  logic [15:0] baudDiv_q;
  logic [15:0] cnt_q;
  logic [3:0]  bitIdx_q;
  logic [7:0]  shift_q;
  logic [15:0] lowCnt_q;
  logic [15:0] breakLen;
  logic        hostBreak_q;
  logic [15:0] replyCnt_q;
  logic        pull_q;
  logic [7:0]  ctl_q;
  logic [15:0] run_q;
  logic        rxPush;
  sdl_pkg::sdl_char_t rxChar_q;
  logic        fifoInReady;
  logic        errEvent;
  logic        lineFall;
  logic        midBit;
  logic        bitEnd;
  logic [7:0]  ctlNext;
  logic        txValidInt;
  logic        brkHit;
  logic        dbgExit;

  // three-stage synchroniser; a change counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync_q    <= 3'b111;
      lineLvl_q <= 1'b1;
    end else begin
      sync_q <= {sync_q[1:0], debug_line_pin_i};
      if (sync_q[1] == sync_q[2]) begin
        lineLvl_q <= sync_q[2];
      end
    end
  end

  assign lineFall = lineLvl_q && (sync_q[1] == sync_q[2]) && !sync_q[2];
  assign midBit   = (cnt_q == (baudDiv_q >> 1));
  assign bitEnd   = (cnt_q == baudDiv_q - 16'h0001);

  // host break: low for nine bit times once locked; held until line high
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lowCnt_q    <= '0;
      hostBreak_q <= 1'b0;
    end else if (lineLvl_q) begin
      lowCnt_q    <= '0;
      hostBreak_q <= 1'b0; // RULE11
    end else begin
      // our own pulled bits never count toward a host break
      if (pull_q) begin
        lowCnt_q <= '0;
      end else if (lowCnt_q != 16'hFFFF) begin
        lowCnt_q <= lowCnt_q + 16'h0001;
      end
      if (baudLocked && !pull_q && lowCnt_q >= breakLen) begin
        hostBreak_q <= 1'b1; // RULE6
      end
    end
  end

  assign breakLen   = 16'(sdl_pkg::BREAK_BITS) * baudDiv_q;
  assign baudLocked = (baudDiv_q != '0);

  // serial errors: framing, collision, break; a break reports once, as the lock drops
  assign errEvent = (hostBreak_q && baudLocked) // RULE6
    || (state_q == SDL_RX && bitEnd && bitIdx_q == 4'd9 && !lineLvl_q) // RULE7
    || (state_q == SDL_TX && midBit && !pull_q && !lineLvl_q); // RULE8
  assign serialError = errEvent;

  // receive/transmit engine with autobaud; one direction at a time
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q    <= SDL_IDLE;
      baudDiv_q  <= '0;
      cnt_q      <= '0;
      bitIdx_q   <= '0;
      shift_q    <= '0;
      pull_q     <= 1'b0;
      replyCnt_q <= '0;
      rxPush     <= 1'b0;
      rxChar_q   <= '0;
    end else begin
      rxPush <= 1'b0;
      if (errEvent || hostBreak_q) begin
        // abort, reset autobaud, and arm a reply break unless a host break caused the abort
        state_q   <= SDL_IDLE; // RULE9 RULE10
        baudDiv_q <= '0;
        cnt_q     <= '0;
        if (!hostBreak_q && replyCnt_q == '0) begin
          replyCnt_q <= 16'(sdl_pkg::REPLY_CHARS * sdl_pkg::CHAR_BITS) * baudDiv_q; // RULE9
          pull_q     <= 1'b1;
        end
      end else if (replyCnt_q != '0) begin
        replyCnt_q <= replyCnt_q - 16'h0001;
        pull_q     <= (replyCnt_q != 16'h0001);
      end else begin
        unique case (state_q)
          SDL_IDLE: begin
            pull_q <= 1'b0;
            if (lineFall) begin
              state_q <= SDL_SYNC; // RULE3
              cnt_q   <= 16'h0001;
            end
          end
          SDL_SYNC: begin
            if (!lineLvl_q) begin
              if (cnt_q != sdl_pkg::BAUD_CNT_MAX) begin
                cnt_q <= cnt_q + 16'h0001; // RULE4
              end
            end else begin
              // eight low bit times measured; divide by eight
              baudDiv_q <= cnt_q >> 3; // RULE3
              cnt_q     <= '0;
              state_q   <= SDL_READY;
            end
          end
          SDL_READY: begin
            if (lineFall) begin
              state_q  <= SDL_RX; // RULE1
              cnt_q    <= 16'h0001;
              bitIdx_q <= '0;
            end else if (txValidInt) begin
              state_q  <= SDL_TX; // RULE1
              shift_q  <= txData;
              cnt_q    <= '0;
              bitIdx_q <= '0;
              pull_q   <= 1'b1; // RULE21
            end
          end
          SDL_RX: begin
            cnt_q <= bitEnd ? 16'h0000 : cnt_q + 16'h0001;
            if (midBit && bitIdx_q >= 4'd1 && bitIdx_q <= 4'd8) begin
              shift_q <= {lineLvl_q, shift_q[7:1]}; // RULE2
            end
            if (bitEnd) begin
              bitIdx_q <= bitIdx_q + 4'd1;
              if (bitIdx_q == 4'd9) begin
                rxChar_q <= '{data: shift_q, frameErr: 1'b0};
                rxPush   <= 1'b1;
                state_q  <= SDL_READY;
              end
            end
          end
          SDL_TX: begin
            cnt_q <= bitEnd ? 16'h0000 : cnt_q + 16'h0001;
            if (bitEnd) begin
              bitIdx_q <= bitIdx_q + 4'd1;
              if (bitIdx_q == 4'd9) begin
                pull_q  <= 1'b0;
                state_q <= SDL_READY;
              end else if (bitIdx_q == 4'd8) begin
                pull_q <= 1'b0; // RULE2
              end else begin
                pull_q  <= !shift_q[0]; // RULE2 RULE21
                shift_q <= {1'b0, shift_q[7:1]};
              end
            end
          end
          default: state_q <= SDL_IDLE;
        endcase
      end
    end
  end

  // transmit request; refused while receiving, replying or unlocked
  assign txValidInt = txValid;
  assign txReady    = (state_q == SDL_READY) && !lineFall && replyCnt_q == '0
                      && !errEvent;

  // open drain: only pull low or release
  assign debug_line_pin_o    = 1'b0; // RULE21
  assign debug_line_pin_oe_n = !pull_q;

  // received characters buffered toward the debug controller
  sdl_fifo #(
    .WIDTH(sdl_pkg::FIFO_WIDTH),
    .DEPTH(sdl_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .inData  (rxChar_q.data),
    .inValid (rxPush),
    .inReady (fifoInReady),
    .outData (rxData),
    .outValid(rxValid),
    .outReady(rxReady),
    .flush   (hostBreak_q)
  );

  // control register write with read-protect guard on the debug flag
  always_comb begin
    ctlNext = ctlWrData;
    if (readProtect && ctl_q[sdl_pkg::DBG_MODE_BIT]) begin
      ctlNext[sdl_pkg::DBG_MODE_BIT] = 1'b1; // RULE20
    end
  end

  // breakpoint hit, and the cycles that take the device out of debug mode
  assign brkHit  = breakInstrDecoded && decodedOpcode == sdl_pkg::BRK_OPCODE
                   && ctl_q[sdl_pkg::BRK_EN_BIT]; // RULE15
  assign dbgExit = sysResetLast ? lineLvl_q
                   : (ctlWrite && !brkHit && !ctlNext[sdl_pkg::DBG_MODE_BIT]); // RULE17

  // control register and debug mode; a host break leaves it untouched
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_q <= sdl_pkg::CTL_RST; // RULE17
    end else if (sysResetLast) begin
      ctl_q[sdl_pkg::DBG_MODE_BIT] <= !lineLvl_q; // RULE16
    end else if (brkHit) begin
      ctl_q[sdl_pkg::DBG_MODE_BIT] <= 1'b1; // RULE15
    end else if (ctlWrite) begin
      ctl_q <= ctlNext; // RULE17 RULE20
    end
  end

  assign debugger_control_register = ctl_q;
  assign debug_mode_flag  = ctl_q[sdl_pkg::DBG_MODE_BIT];
  assign fetchHalt        = debug_mode_flag; // RULE13
  assign haltExit         = debug_mode_flag; // RULE14
  assign watchdogRefresh  = debug_mode_flag && watchdogEnabled; // RULE14
  assign stopWakeReset    = stopMode && !lineLvl_q; // RULE18

  // saturating runtime counter, cleared on debug-mode exit
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      run_q <= sdl_pkg::RUN_CNT_RST;
    end else if (debug_mode_flag) begin
      if (dbgExit) begin
        run_q <= sdl_pkg::RUN_CNT_RST; // RULE19
      end
    end else if (run_q != sdl_pkg::RUN_CNT_MAX) begin
      run_q <= run_q + 16'h0001; // RULE19
    end
  end

  assign runtimeCount = run_q;
endmodule

// ==== tb/sdl_link_chk.sv ====
// concurrent checks on the debug link ports, bound into every sdl_link
// assumes the single ref_clk domain and the active-low rstn of the design
`timescale 1ns/1ps
module sdl_link_chk (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        debug_line_pin_i,
  input wire logic        ctlWrite,
  input wire logic [7:0]  ctlWrData,
  input wire logic [7:0]  debugger_control_register,
  input wire logic        readProtect,
  input wire logic        breakInstrDecoded,
  input wire logic [7:0]  decodedOpcode,
  input wire logic        stopMode,
  input wire logic        sysResetLast,
  input wire logic        debug_mode_flag,
  input wire logic        fetchHalt,
  input wire logic        haltExit,
  input wire logic        watchdogRefresh,
  input wire logic        watchdogEnabled,
  input wire logic        stopWakeReset,
  input wire logic [15:0] runtimeCount,
  input wire logic        baudLocked,
  input wire logic        serialError
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // debug flag drives the halt outputs and watchdog refresh
  flag_mirror_a: assert property (debug_mode_flag == debugger_control_register[7]
    && fetchHalt == debug_mode_flag && haltExit == debug_mode_flag)
    else $error("halt outputs differ from debug flag");
  wdog_refresh_a: assert property (watchdogRefresh == (debug_mode_flag && watchdogEnabled))
    else $error("watchdog refresh wrong");
  stop_wake_a: assert property ((stopMode && !debug_line_pin_i) [*5] |-> stopWakeReset)
    else $error("no reset request from low line in stop");
  protect_keep_a: assert property (readProtect && debug_mode_flag && ctlWrite
    && !sysResetLast |=> debug_mode_flag)
    else $error("protected debug flag was cleared");
  ctl_write_a: assert property (ctlWrite && !readProtect && !breakInstrDecoded
    && !sysResetLast |=> debugger_control_register == $past(ctlWrData))
    else $error("control write lost");
  brk_enter_a: assert property (breakInstrDecoded && decodedOpcode == 8'h00
    && debugger_control_register[5] && !ctlWrite && !sysResetLast |=> debug_mode_flag)
    else $error("break opcode did not enter debug mode");
  brk_nop_a: assert property (breakInstrDecoded && !debug_mode_flag && !ctlWrite
    && !sysResetLast && !(decodedOpcode == 8'h00 && debugger_control_register[5])
    |=> !debug_mode_flag)
    else $error("disabled break entered debug mode");
  run_hold_a: assert property (debug_mode_flag ##1 debug_mode_flag |-> $stable(runtimeCount))
    else $error("runtime counter moved in debug mode");
  run_count_a: assert property (rstn && !debug_mode_flag && !ctlWrite && !sysResetLast
    && runtimeCount != 16'hFFFF ##1 !debug_mode_flag
    |-> runtimeCount == $past(runtimeCount) + 16'h0001)
    else $error("runtime counter did not step");
  run_sat_a: assert property (runtimeCount == 16'hFFFF && !ctlWrite && !sysResetLast
    |=> runtimeCount == 16'hFFFF)
    else $error("runtime counter wrapped");
  err_unlock_a: assert property (serialError |-> ##[0:2] !baudLocked)
    else $error("bit rate kept after serial error");
endmodule

bind sdl_link sdl_link_chk u_chk (.ref_clk, .rstn, .debug_line_pin_i, .ctlWrite, .ctlWrData,
  .debugger_control_register, .readProtect, .breakInstrDecoded, .decodedOpcode, .stopMode,
  .sysResetLast, .debug_mode_flag, .fetchHalt, .haltExit, .watchdogRefresh, .watchdogEnabled,
  .stopWakeReset, .runtimeCount, .baudLocked, .serialError);

// ==== tb/sdl_host_model.sv ====
// behavioural debug host on the open-drain line: sends, receives, breaks
// assumes the bench resolves the line level from every pull-low request
`timescale 1ns/1ps
module sdl_host_model #(
  parameter int BIT = 16 // clock / 16 sits inside the allowed rates
) (
  input  wire logic ref_clk,
  input  wire logic lineLevel,
  output logic      hostPull
);
  initial hostPull = 1'b0;

  // one character: start low, data lsb first, stop level chosen by caller
  task automatic sendChar(input logic [7:0] v, input logic stopHigh);
    logic [9:0] f;
    f = {stopHigh, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      hostPull <= !f[i];
      repeat (BIT) @(posedge ref_clk);
    end
    // a high stop bit is already released; a low one is let go here
    if (!stopHigh) begin
      hostPull <= 1'b0;
    end
  endtask

  // hold the line low, a break when long enough, even over device traffic
  task automatic pullLow(input int n);
    hostPull <= 1'b1;
    repeat (n) @(posedge ref_clk);
    hostPull <= 1'b0;
  endtask

  // listen only, never driving while the device sends
  task automatic getChar(output logic [7:0] v);
    v = 8'h00;
    for (int k = 0; k < 5000 && lineLevel !== 1'b0; k++) @(posedge ref_clk);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge ref_clk);
      v[i] = lineLevel;
    end
  endtask
endmodule

// ==== tb/sdl_link_tb_top.sv ====
// self-checking bench of sdl_link with a host model and a reference queue
// assumes a 10 MHz clock and pull-up resolution of the line done here
`timescale 1ns/1ps
module sdl_link_tb_top;
  localparam int BIT = 16;
  logic ref_clk, rstn, line, oeN, hostPull, rxValid, rxReady, txValid, txReady, ctlWrite;
  logic readProtect, brkDec, stopMode, sysLast, dbgFlag, wdEn, stopWake, locked, serErr;
  logic [7:0] rxData, txData, ctlWrData, ctlReg, opcode, b, got, rxQ[$];
  logic [15:0] runCnt;
  int num_errors, num_checks, cyc, errSeen, n, rc;

  // pull-up wins unless a party pulls low
  assign line = oeN & !hostPull;

  sdl_host_model #(.BIT(BIT)) host (.ref_clk, .lineLevel(line), .hostPull);
  sdl_link dut (.ref_clk, .rstn, .debug_line_pin_i(line), .debug_line_pin_o(),
    .debug_line_pin_oe_n(oeN), .rxData, .rxValid, .rxReady, .txData, .txValid, .txReady,
    .ctlWrite, .ctlWrData, .debugger_control_register(ctlReg), .readProtect,
    .breakInstrDecoded(brkDec), .decodedOpcode(opcode), .stopMode, .sysResetLast(sysLast),
    .debug_mode_flag(dbgFlag), .fetchHalt(), .haltExit(), .watchdogRefresh(),
    .watchdogEnabled(wdEn), .stopWakeReset(stopWake), .runtimeCount(runCnt),
    .baudLocked(locked), .serialError(serErr));

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = !ref_clk;
  end

  // error pulse counter and hang limit
  always @(negedge ref_clk) begin
    cyc++;
    if (serErr === 1'b1) errSeen++;
    if (cyc == 90000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // one-cycle strobe: 0 control write, 1 decoded opcode, 2 last reset cycle
  task automatic strobe(input int k, input logic [7:0] v, input logic p);
    @(posedge ref_clk);
    ctlWrite <= (k == 0);
    brkDec <= (k == 1);
    sysLast <= (k == 2);
    ctlWrData <= v;
    opcode <= v;
    readProtect <= p;
    wdEn <= 1'($urandom);
    @(posedge ref_clk);
    ctlWrite <= 1'b0;
    brkDec <= 1'b0;
    sysLast <= 1'b0;
    #1;
  endtask

  // hold the byte until the edge that takes it
  task automatic sendTx(input logic [7:0] v);
    logic r;
    r = 1'b0;
    @(posedge ref_clk);
    txData <= v;
    txValid <= 1'b1;
    for (int i = 0; i < 2000 && !r; i++) begin
      #1 r = (txReady === 1'b1);
      @(posedge ref_clk);
    end
    txValid <= 1'b0;
  endtask

  // wait out any reply break, then send the sync character
  task automatic resync();
    for (int i = 0; i < 2000 && oeN === 1'b0; i++) @(posedge ref_clk);
    repeat (BIT * 2) @(posedge ref_clk);
    host.sendChar(8'h80, 1'b1);
    repeat (BIT * 2) @(posedge ref_clk);
    #1 chk(locked, 1);
  endtask

  initial begin
    {rstn, rxReady, txValid, txData, ctlWrite, ctlWrData, readProtect} = '0;
    {brkDec, opcode, stopMode, sysLast, wdEn} = '0;
    void'($urandom(32'he091_36a7));
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    #1 chk({ctlReg, oeN, locked}, {8'h00, 2'b10});
    resync();
    $display("test sync done");
    // fill the receive fifo while stalled, then drain against the queue
    for (int i = 0; i < 16; i++) begin
      b = 8'($urandom);
      rxQ.push_back(b);
      host.sendChar(b, 1'b1);
    end
    @(posedge ref_clk);
    rxReady <= 1'b1;
    for (int i = 0; i < 200 && rxQ.size() > 0; i++) begin
      #1 if (rxValid === 1'b1) chk(rxData, rxQ.pop_front());
      @(posedge ref_clk);
    end
    rxReady <= 1'b0;
    #1 chk({rxValid, 8'(rxQ.size())}, 9'h000);
    b = 8'($urandom);
    fork
      host.getChar(got);
      sendTx(b);
    join
    chk(got, b);
    $display("test traffic done");
    // framing error: reply break of four characters
    repeat (BIT * 4) @(posedge ref_clk);
    n = errSeen;
    host.sendChar(8'($urandom), 1'b0);
    for (int i = 0; i < 200 && oeN !== 1'b0; i++) @(posedge ref_clk);
    for (rc = 0; rc < 5000 && oeN === 1'b0; rc++) @(posedge ref_clk);
    chk(errSeen, n + 1);
    chk({locked, rc >= 39 * BIT, rc <= 41 * BIT}, 3'b011);
    resync();
    // collision while sending all-high data
    n = errSeen;
    fork
      sendTx(8'hFF);
      begin
        repeat (BIT * 3) @(posedge ref_clk);
        host.pullLow(BIT * 2);
      end
    join
    repeat (BIT * 4) @(posedge ref_clk);
    chk({31'(errSeen), locked}, {31'(n + 1), 1'b0});
    $display("test errors done");
    // breakpoints disabled then enabled
    for (int en = 0; en < 2; en++) begin
      strobe(0, en ? 8'h20 : 8'h00, 1'b0);
      strobe(1, 8'h5A, 1'b0);
      chk(dbgFlag, 0);
      strobe(1, 8'h00, 1'b0);
      chk(dbgFlag, en);
    end
    rc = runCnt;
    repeat (20) @(posedge ref_clk);
    #1 chk(runCnt, rc);
    strobe(0, 8'h20, 1'b1);
    chk(ctlReg, 8'hA0);
    // host break in debug mode, stop mode wake on the low line
    resync();
    fork
      host.pullLow(BIT * 12);
      begin
        repeat (BIT * 10) @(posedge ref_clk);
        stopMode <= 1'b1;
        repeat (8) @(posedge ref_clk);
        #1 chk({locked, stopWake}, 2'b01);
        @(posedge ref_clk);
        stopMode <= 1'b0;
      end
    join
    repeat (8) @(posedge ref_clk);
    #1 chk({ctlReg, stopWake}, {8'hA0, 1'b0});
    strobe(0, 8'h00, 1'b0);
    chk(dbgFlag, 0);
    rc = runCnt;
    repeat (20) @(posedge ref_clk);
    #1 chk(runCnt, rc + 20);
    // last reset cycle samples the line
    fork
      host.pullLow(BIT * 4);
      begin
        repeat (BIT * 2) @(posedge ref_clk);
        strobe(2, 8'h00, 1'b0);
        chk(dbgFlag, 1);
      end
    join
    repeat (BIT) @(posedge ref_clk);
    strobe(2, 8'h00, 1'b0);
    chk(dbgFlag, 0);
    chk(runCnt, 16'h0000);
    $display("test debug mode done");
    repeat (66000) @(posedge ref_clk);
    #1 chk(runCnt, 16'hFFFF);
    $display("test runtime done");
    stop_test();
  end
endmodule
